// *** core/bus_term_pkg.sv ***
// Shared types and constants for the bus termination controller
package bus_term_pkg;

  // ****************
  // Fixed fault vector number and address
  // ****************
  localparam logic [23:0] FAULT_VECTOR_ADDR = 24'h000008;
  localparam logic [7:0] FAULT_VECTOR_NUM = 8'h02;

  // ****************
  // Synchroniser lanes and reset level (pins are active low)
  // ****************
  localparam int SYNC_W = 4;
  localparam int LANE_ACK = 0;
  localparam int LANE_FAULT = 1;
  localparam int LANE_HALT = 2;
  localparam int LANE_BREQ = 3;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 4'hf;

  // ****************
  // Types
  // ****************
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0] fc;
    logic [15:0] wdata;
    logic write;
    logic rmw;
  } bus_req_t;

  localparam bus_req_t REQ_RESET = '0;

  typedef struct packed {
    logic done;
    logic [15:0] rdata;
  } bus_rsp_t;

  typedef struct packed {
    logic start;
    logic [7:0] vector;
    logic [23:0] vector_addr;
  } exc_req_t;

  typedef struct packed {
    logic halted_by_pin;
    logic rerun_wait;
    logic double_fault;
  } stop_status_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_WAIT = 4'h2,
    ST_TERM_OK = 4'h3,
    ST_TERM_FAULT = 4'h4,
    ST_FLOAT = 4'h5,
    ST_RERUN = 4'h6,
    ST_STOPPED = 4'h7,
    ST_DFAULT = 4'h8
  } term_state_t;

endpackage

// *** core/bus_term_ctrl.sv ***
// Bus cycle termination: fault, stop, re-run, single step and double fault
`timescale 1ns/1ps
`default_nettype none

module bus_term_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire bus_term_pkg::bus_req_t i_req,
  input wire logic i_req_valid,
  output logic o_req_ready,
  output bus_term_pkg::bus_rsp_t o_rsp,
  output bus_term_pkg::exc_req_t o_exc,
  input wire logic i_instr_start,
  input wire logic i_transfer_ack_n,
  input wire logic i_bus_fault_in_n,
  input wire logic i_halt_n,
  input wire logic i_bus_req_n,
  output logic o_bus_grant_n,
  output logic o_address_strobe_n,
  output logic o_read_write,
  output logic [23:0] o_addr,
  output logic [2:0] o_function_code_lines,
  output logic o_addr_oe_n,
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic o_data_oe_n,
  output bus_term_pkg::stop_status_t o_status
);
  import bus_term_pkg::*;

  // ****************
  // Input synchronisers
  // ****************
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic ack;
  logic fault;
  logic halt;
  logic breq;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_reg <= SYNC_RESET;
      sync_reg <= SYNC_RESET;
    end
    else
    begin
      meta_reg <= {i_bus_req_n, i_halt_n, i_bus_fault_in_n, i_transfer_ack_n};
      sync_reg <= meta_reg;
    end
  end

  assign ack = !sync_reg[LANE_ACK];
  assign fault = !sync_reg[LANE_FAULT];
  assign halt = !sync_reg[LANE_HALT];
  assign breq = !sync_reg[LANE_BREQ];

  // ****************
  // State machine
  // ****************
  term_state_t state_reg;
  term_state_t state_next;
  bus_req_t req_reg;
  logic boot_reg;
  logic exc_active_reg;
  logic grant_reg;
  logic start_cycle;
  logic exc_fire;
  logic double_hit;

  function automatic logic cycle_busy(input term_state_t s);
    cycle_busy = (s == ST_ADDR) || (s == ST_WAIT) || (s == ST_TERM_OK) || (s == ST_TERM_FAULT);
  endfunction

  assign o_req_ready = (state_reg == ST_IDLE) && !halt && !grant_reg;
  assign start_cycle = o_req_ready && i_req_valid;
  assign double_hit = boot_reg || exc_active_reg;
  assign exc_fire = (state_reg == ST_FLOAT) && !fault && !double_hit;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (start_cycle)
          state_next = ST_ADDR;
      ST_ADDR:
        state_next = ST_WAIT;
      ST_WAIT:
        if (fault)
          state_next = ST_TERM_FAULT;
        else if (ack)
          state_next = ST_TERM_OK;
      ST_TERM_OK:
        state_next = halt ? ST_STOPPED : ST_IDLE;
      ST_TERM_FAULT:
        if (halt && !req_reg.rmw)
          state_next = ST_RERUN;
        else
          state_next = ST_FLOAT;
      ST_FLOAT:
        if (!fault)
          state_next = double_hit ? ST_DFAULT : ST_IDLE;
      // A re-run waits until halt is released and no other master holds the bus
      ST_RERUN:
        if (!halt && !grant_reg)
          state_next = fault ? ST_FLOAT : ST_ADDR;
      ST_STOPPED:
        if (!halt)
          state_next = ST_IDLE;
      ST_DFAULT:
        state_next = ST_DFAULT;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Request is held for the whole cycle so a re-run repeats it exactly
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      req_reg <= REQ_RESET;
    end
    else if (start_cycle)
    begin
      req_reg <= i_req;
    end
  end

  // ****************
  // Double fault tracking
  // ****************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      boot_reg <= 1'b1;
      exc_active_reg <= 1'b0;
    end
    else
    begin
      if (i_instr_start)
      begin
        boot_reg <= 1'b0;
      end
      if (exc_fire)
      begin
        exc_active_reg <= 1'b1;
      end
      else if (i_instr_start)
      begin
        exc_active_reg <= 1'b0;
      end
    end
  end

  // ****************
  // Exception request and read response
  // ****************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_exc <= '0;
      o_rsp <= '0;
    end
    else
    begin
      o_exc.start <= exc_fire;
      o_exc.vector <= FAULT_VECTOR_NUM;
      o_exc.vector_addr <= FAULT_VECTOR_ADDR;
      o_rsp.done <= (state_reg == ST_WAIT) && ack && !fault;
      if ((state_reg == ST_WAIT) && ack && !fault && !req_reg.write)
      begin
        o_rsp.rdata <= i_data;
      end
    end
  end

  // ****************
  // Bus pins
  // ****************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_address_strobe_n <= 1'b1;
      o_addr_oe_n <= 1'b1;
      o_data_oe_n <= 1'b1;
      o_read_write <= 1'b1;
      o_addr <= '0;
      o_function_code_lines <= '0;
      o_data <= '0;
    end
    else
    begin
      o_address_strobe_n <= !((state_next == ST_ADDR) || (state_next == ST_WAIT));
      o_addr_oe_n <= !((cycle_busy(state_next) && (state_next != ST_TERM_FAULT))
        || (state_next == ST_IDLE));
      o_data_oe_n <= !(cycle_busy(state_next) && (state_next != ST_TERM_FAULT)
        && req_reg.write);
      if (start_cycle)
      begin
        o_read_write <= !i_req.write;
        o_addr <= i_req.addr;
        o_function_code_lines <= i_req.fc;
        o_data <= i_req.wdata;
      end
    end
  end

  // ****************
  // Arbitration, independent of stop
  // ****************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      grant_reg <= 1'b0;
    end
    else
    begin
      grant_reg <= breq && (grant_reg || !cycle_busy(state_next));
    end
  end

  assign o_bus_grant_n = !grant_reg;

  // ****************
  // Stop status
  // ****************
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_status <= '0;
    end
    else
    begin
      o_status.halted_by_pin <= (state_next == ST_STOPPED);
      o_status.rerun_wait <= (state_next == ST_RERUN);
      o_status.double_fault <= (state_next == ST_DFAULT);
    end
  end

  // ****************
  // Assertions
  // ****************
  property p_fault_ends;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_WAIT && fault) |=> (state_reg == ST_TERM_FAULT);
  endproperty
  a_fault_ends: assert property (p_fault_ends) else $error("fault did not end cycle");

  property p_strobe_drop;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_WAIT && fault) |=> o_address_strobe_n;
  endproperty
  a_strobe_drop: assert property (p_strobe_drop) else $error("strobe kept on fault");

  property p_float_held;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_TERM_FAULT || state_reg == ST_FLOAT) |-> (o_addr_oe_n && o_data_oe_n);
  endproperty
  a_float_held: assert property (p_float_held) else $error("bus driven during fault");

  property p_exc_vector;
    @(posedge i_clk) disable iff (!i_nrst)
    o_exc.start |-> ($past(state_reg) == ST_FLOAT && o_exc.vector_addr == FAULT_VECTOR_ADDR);
  endproperty
  a_exc_vector: assert property (p_exc_vector) else $error("bad fault exception start");

  property p_rerun_same;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_RERUN && !halt && !fault && !grant_reg) |=> (state_reg == ST_ADDR)
      ##1 (o_addr == $past(o_addr, 2) && !o_address_strobe_n);
  endproperty
  a_rerun_same: assert property (p_rerun_same) else $error("re-run not identical");

  property p_no_rmw_rerun;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_TERM_FAULT && req_reg.rmw) |=> (state_reg == ST_FLOAT);
  endproperty
  a_no_rmw_rerun: assert property (p_no_rmw_rerun) else $error("indivisible cycle re-run");

  property p_halt_quiet;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_IDLE && halt) |=> (state_reg != ST_ADDR);
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("cycle started while stopped");

  property p_double;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_FLOAT && !fault && double_hit) |=> o_status.double_fault [*3];
  endproperty
  a_double: assert property (p_double) else $error("double fault not held");

  property p_dfault_stuck;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_DFAULT) |=> (state_reg == ST_DFAULT && o_addr_oe_n);
  endproperty
  a_dfault_stuck: assert property (p_dfault_stuck) else $error("left double fault");

  property p_grant_stopped;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_reg == ST_STOPPED && breq) |=> !o_bus_grant_n;
  endproperty
  a_grant_stopped: assert property (p_grant_stopped) else $error("no grant while stopped");

  c_rerun: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == ST_RERUN ##[1:50] state_reg == ST_ADDR);
  c_exc: cover property (@(posedge i_clk) disable iff (!i_nrst) o_exc.start);
  c_step: cover property (@(posedge i_clk) disable iff (!i_nrst)
    state_reg == ST_TERM_OK ##1 state_reg == ST_STOPPED);
  c_dfault: cover property (@(posedge i_clk) disable iff (!i_nrst) o_status.double_fault);

endmodule

`default_nettype wire

// *** testbench/bus_partner.sv ***
// Far-side slave, watchdog and stop logic model
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic i_clk,
  input wire logic i_strobe_n,
  input wire logic [23:0] i_addr,
  input wire logic [1:0] i_mode,
  input wire logic [1:0] i_wait,
  input wire logic i_stop,
  output logic o_ack_n,
  output logic o_fault_n,
  output logic o_halt_n,
  output logic [15:0] o_data
);
  // ****************
  // Modes: 0 ack, 1 fault with ack, 2 fault alone
  // ****************
  logic [2:0] cnt_reg;
  logic [15:0] last_reg;
  initial
  begin
    o_ack_n = 1'b1;
    o_fault_n = 1'b1;
    o_halt_n = 1'b1;
    cnt_reg = 3'h0;
    last_reg = 16'h0;
  end
  // Released data bus shows the inverse of the last value
  assign o_data = i_strobe_n ? ~last_reg : i_addr[15:0] ^ 16'h5a5a;
  always @(posedge i_clk)
  begin
    o_halt_n <= ~i_stop;
    if (i_strobe_n)
    begin
      cnt_reg <= 3'h0;
      o_ack_n <= 1'b1;
      o_fault_n <= 1'b1;
    end
    else
    begin
      last_reg <= o_data;
      if (cnt_reg < {1'b0, i_wait})
        cnt_reg <= cnt_reg + 3'h1;
      else
      begin
        o_ack_n <= i_mode[1];
        o_fault_n <= (i_mode == 2'h0);
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/tb_bus_term_ctrl.sv ***
// Testbench for the bus termination controller
`timescale 1ns/1ps
`default_nettype none
module tb_bus_term_ctrl;
  import bus_term_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  bus_req_t req = REQ_RESET;
  logic req_valid = 1'b0;
  logic instr_start = 1'b0;
  logic bus_req_n = 1'b1;
  logic stop = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] dly = 2'h0;
  logic last_rd = 1'b0;
  logic ack_n, fault_n, halt_n, grant_n, strobe_n, rw, aoe_n, doe_n, ready;
  logic [23:0] addr;
  logic [23:0] a;
  logic [2:0] fc;
  logic [15:0] din, dout;
  bus_rsp_t rsp;
  exc_req_t exc;
  stop_status_t status;
  logic [32:0] exp_q[$];
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // ****************
  // Design, far side and checking
  // ****************
  bus_term_ctrl u_bus_term_ctrl (.i_clk(clk), .i_nrst(nrst), .i_req(req),
    .i_req_valid(req_valid), .o_req_ready(ready), .o_rsp(rsp), .o_exc(exc),
    .i_instr_start(instr_start), .i_transfer_ack_n(ack_n), .i_bus_fault_in_n(fault_n),
    .i_halt_n(halt_n), .i_bus_req_n(bus_req_n), .o_bus_grant_n(grant_n),
    .o_address_strobe_n(strobe_n), .o_read_write(rw), .o_addr(addr),
    .o_function_code_lines(fc), .o_addr_oe_n(aoe_n), .i_data(din), .o_data(dout),
    .o_data_oe_n(doe_n), .o_status(status));
  bus_partner u_bus_partner (.i_clk(clk), .i_strobe_n(strobe_n), .i_addr(addr),
    .i_mode(mode), .i_wait(dly), .i_stop(stop), .o_ack_n(ack_n), .o_fault_n(fault_n),
    .o_halt_n(halt_n), .o_data(din));
  initial
    forever #5 clk = ~clk;
  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic take(input logic k, input logic [31:0] g);
    logic [32:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff;
    chk("result kind", {31'h0, e[32]}, {31'h0, k});
    chk("result value", e[31:0], g);
  endtask
  always @(negedge clk)
  begin
    if (rsp.done === 1'b1)
      take(1'b0, {16'h0, last_rd ? rsp.rdata : 16'h0});
    if (exc.start === 1'b1)
      take(1'b1, {exc.vector, exc.vector_addr});
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic note(input string s);
    $display("Test %s finished", s);
  endtask
  task automatic issue(input logic [23:0] ad, input logic wr, input logic rm,
    input logic [1:0] m, input logic st);
    int n;
    n = 0;
    @(posedge clk);
    mode <= m;
    dly <= (m == 2'h0) ? 2'($urandom) : 2'h3;
    req <= {ad, 3'h5, ad[15:0] ^ 16'h1234, wr, rm};
    req_valid <= 1'b1;
    last_rd = ~wr;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (ready !== 1'b1 && n < 200);
    if (n == 200)
    begin
      bad_count++;
      $display("Error request wait expected ready seen timeout");
    end
    @(posedge clk);
    req_valid <= 1'b0;
    stop <= st;
  endtask
  task automatic settle(input logic strobe);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((strobe ? strobe_n !== 1'b0 : (ready !== 1'b1 && status === 3'h0
      && exc.start !== 1'b1)) && n < 100);
    if (n == 100)
    begin
      bad_count++;
      $display("Error settle wait expected event seen timeout");
    end
  endtask
  task automatic start_instr();
    @(posedge clk);
    instr_start <= 1'b1;
    @(posedge clk);
    instr_start <= 1'b0;
  endtask
  initial
  begin
    void'($urandom(73593));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    issue(24'h00a5a4, 1'b1, 1'b0, 2'h2, 1'b1);
    settle(1'b0);
    chk("rerun wait", 32'h2, {30'h0, status.rerun_wait, status.double_fault});
    chk("float", 32'h3, {30'h0, aoe_n, doe_n});
    exp_q.push_back(33'h0);
    @(posedge clk);
    mode <= 2'h0;
    @(posedge clk);
    stop <= 1'b0;
    settle(1'b1);
    chk("rerun addr", 32'h0500a5a4, {5'h0, fc, addr});
    chk("rerun data", 32'h0000b790, {15'h0, rw, dout});
    settle(1'b0);
    chk("status", 32'h0, {29'h0, status});
    note("rerun");
    start_instr();
    for (int i = 0; i < 8; i++)
    begin
      a = 24'($urandom);
      issue(a, a[0], 1'b0, 2'h0, 1'b0);
      exp_q.push_back({17'h0, a[0] ? 16'h0 : a[15:0] ^ 16'h5a5a});
      settle(1'b0);
    end
    note("normal");
    a = 24'($urandom);
    issue(a, 1'b0, 1'b0, 2'h0, 1'b1);
    exp_q.push_back({17'h0, a[15:0] ^ 16'h5a5a});
    settle(1'b0);
    chk("halted", 32'h1, {31'h0, status.halted_by_pin});
    chk("float", 32'h3, {30'h0, aoe_n, doe_n});
    @(posedge clk);
    bus_req_n <= 1'b0;
    repeat (6) @(negedge clk);
    chk("grant", 32'h0, {31'h0, grant_n});
    chk("idle", 32'h2, {30'h0, strobe_n, ready});
    @(posedge clk);
    bus_req_n <= 1'b1;
    stop <= 1'b0;
    note("stop");
    issue(24'($urandom), 1'b0, 1'b1, 2'h2, 1'b1);
    exp_q.push_back({1'b1, 32'h02000008});
    settle(1'b0);
    chk("no rerun", 32'h0, {31'h0, status.rerun_wait});
    @(posedge clk);
    stop <= 1'b0;
    start_instr();
    note("indivisible");
    issue(24'h000100, 1'b1, 1'b0, 2'h1, 1'b0);
    exp_q.push_back({1'b1, 32'h02000008});
    settle(1'b0);
    issue(24'h000102, 1'b0, 1'b0, 2'h2, 1'b0);
    settle(1'b0);
    repeat (20) @(negedge clk);
    chk("double", 32'h2, {30'h0, status.double_fault, ready});
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("cleared", 32'h0, {29'h0, status});
    note("double");
    issue(24'h000004, 1'b0, 1'b0, 2'h1, 1'b0);
    settle(1'b0);
    chk("boot fault", 32'h1, {31'h0, status.double_fault});
    chk("pending", 32'h0, exp_q.size());
    note("boot");
    conclude();
  end
endmodule
`default_nettype wire
